// File: inc/psa_map.svh
// Offsets, field positions, reset values and masks of the program space access unit
// Assumes a 32-bit Avalon-MM slave with byte addresses and one aligned word per register
`ifndef PSA_MAP_SVH
`define PSA_MAP_SVH

`define PSA_ADDR_TABLE_PAGE 5'h00
`define PSA_ADDR_VIS_PAGE   5'h04
`define PSA_ADDR_CORE_CTRL  5'h08
`define PSA_ADDR_STATUS     5'h0C
`define PSA_ADDR_PC         5'h10

`define PSA_RST_PAGE        8'h00
`define PSA_RST_PC          24'h000000
`define PSA_VIS_EN_BIT      2
`define PSA_CFG_BIT         7
`define PSA_EA_MSB          15
`define PSA_PC_STEP         24'h000002

`define PSA_MASK_NONE       3'h0
`define PSA_MASK_LOW_BYTE   3'h1
`define PSA_MASK_MID_BYTE   3'h2
`define PSA_MASK_LOW_WORD   3'h3
`define PSA_MASK_HIGH       3'h4

`endif

// File: inc/psa_pkg.sv
// Types of the program space access unit
// Assumes psa_map.svh supplies the numeric constants
package psa_pkg;

  typedef enum logic [4:0] {
    PSA_IDLE   = 5'h01,
    PSA_ISSUE  = 5'h02,
    PSA_SECOND = 5'h04,
    PSA_CAPT   = 5'h08,
    PSA_WDONE  = 5'h10
  } psa_fsm_e;

  typedef enum logic [2:0] {
    PSA_DATA_READ        = 3'h0,
    PSA_DATA_WRITE       = 3'h1,
    PSA_TABLE_READ_LOW   = 3'h2,
    PSA_TABLE_READ_HIGH  = 3'h3,
    PSA_TABLE_WRITE_LOW  = 3'h4,
    PSA_TABLE_WRITE_HIGH = 3'h5
  } psa_op_e;

  typedef enum logic {
    PSA_LIT_BRANCH  = 1'b0,
    PSA_LIT_DISABLE = 1'b1
  } psa_lit_e;

  typedef struct packed {
    psa_fsm_e    fsm;
    psa_op_e     op;
    logic        byte_mode;
    logic        vis;
    logic [15:0] ea;
    logic [7:0]  table_page;
    logic [7:0]  visibility_page;
    logic        visibility_enable;
    logic        av_wait;
    logic [31:0] av_rdata;
    logic [23:0] pm_addr;
    logic        pm_rd;
    logic        pm_wr;
    logic [23:0] pm_wdata;
    logic [2:0]  pm_wmask;
    logic        pm_cfg;
    logic        done;
    logic        data_space;
    logic        refused;
    logic [15:0] rdata;
    logic        cfg_last;
    logic [23:0] program_counter;
    logic [13:0] disable_count;
  } psa_state_s;

endpackage : psa_pkg

// File: design/psa_lane.sv
// Read data steering from a 24-bit program word onto a 16-bit data word
// Assumes the caller supplies the fetched word and the byte select from EA bit 0
`timescale 1ns/1ns
module psa_lane
  import psa_pkg::*;
(
  input  wire logic [23:0] word,
  input  wire logic        high_word,
  input  wire logic        byte_mode,
  input  wire logic        byte_sel,
  output logic      [15:0] data
);

  always_comb begin
    data = 16'h0000;
    if (!high_word) begin
      if (!byte_mode) begin
        data = word[15:0];
      end else if (byte_sel) begin
        data = {8'h00, word[15:8]};
      end else begin
        data = {8'h00, word[7:0]};
      end
    end else begin
      if (!byte_mode) begin
        data = {8'h00, word[23:16]};
      end else if (byte_sel) begin
        data = 16'h0000;
      end else begin
        data = {8'h00, word[23:16]};
      end
    end
  end

endmodule : psa_lane

// File: design/psa_top.sv
// Program space access unit: table and visibility paths into 24-bit program memory
// Assumes program memory returns read data the cycle after pm_rd and writes on pm_wr
`timescale 1ns/1ns
`include "psa_map.svh"
module psa_top
  import psa_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        core_req,
  input  wire logic [2:0]  core_op,
  input  wire logic        core_byte,
  input  wire logic [15:0] core_ea_base,
  input  wire logic        core_indexed,
  input  wire logic [15:0] core_offset,
  input  wire logic [15:0] core_wdata,
  output logic             core_done,
  output logic      [15:0] core_rdata,
  output logic             core_data_space,
  output logic             core_refused,
  input  wire logic        pc_step,
  input  wire logic        lit_valid,
  input  wire logic        lit_kind,
  input  wire logic [15:0] lit_field,
  output logic      [23:0] program_counter,
  output logic      [13:0] disable_count,
  output logic      [23:0] pm_addr,
  output logic             pm_rd,
  output logic             pm_wr,
  output logic      [23:0] pm_wdata,
  output logic      [2:0]  pm_wmask,
  output logic             pm_cfg,
  input  wire logic [23:0] pm_rdata
);

  psa_state_s  st_reg;
  psa_state_s  st_next;
  logic [15:0] lane_data;
  logic [15:0] ea_now;
  logic        vis_hit;
  logic        idle_go;

  // Base plus shared offset when the operand is indexed
  function automatic logic [15:0] calc_ea(input logic [15:0] base,
                                          input logic        indexed,
                                          input logic [15:0] offset);
    logic [15:0] sum;
    sum = base + offset;
    calc_ea = indexed ? sum : base;
  endfunction : calc_ea

  function automatic logic [23:0] table_addr(input logic [7:0]  page,
                                             input logic [15:0] ea);
    table_addr = {page, ea};
  endfunction : table_addr

  function automatic logic [23:0] vis_addr(input logic [7:0]  page,
                                           input logic [15:0] ea);
    vis_addr = {1'b0, page, ea[14:0]};
  endfunction : vis_addr

  // Lane mask in [26:24], lane data in [23:0]
  function automatic logic [26:0] write_lanes(input logic        high,
                                              input logic        byte_mode,
                                              input logic        bsel,
                                              input logic [15:0] wdata);
    logic [26:0] r;
    r = {`PSA_MASK_NONE, 24'h000000};
    if (high) begin
      if (!(byte_mode && bsel)) begin
        r = {`PSA_MASK_HIGH, wdata[7:0], 16'h0000};
      end
    end else if (!byte_mode) begin
      r = {`PSA_MASK_LOW_WORD, 8'h00, wdata};
    end else if (bsel) begin
      r = {`PSA_MASK_MID_BYTE, 8'h00, wdata[7:0], 8'h00};
    end else begin
      r = {`PSA_MASK_LOW_BYTE, 16'h0000, wdata[7:0]};
    end
    write_lanes = r;
  endfunction : write_lanes

  psa_lane u_lane (
    .word      (pm_rdata),
    .high_word (st_reg.op == PSA_TABLE_READ_HIGH),
    .byte_mode (st_reg.byte_mode),
    .byte_sel  (st_reg.ea[0]),
    .data      (lane_data)
  );

  assign ea_now = calc_ea(core_ea_base, core_indexed, core_offset);
  assign vis_hit = st_reg.visibility_enable && ea_now[`PSA_EA_MSB];
  assign idle_go = (st_reg.fsm == PSA_IDLE) && core_req && !st_reg.done;

  always_comb begin
    logic [26:0] wl;
    logic [31:0] rd;
    wl = 27'h0000000;
    rd = 32'h00000000;
    st_next = st_reg;
    st_next.done = 1'b0;
    st_next.data_space = 1'b0;
    st_next.refused = 1'b0;
    st_next.pm_rd = 1'b0;
    st_next.pm_wr = 1'b0;

    // Avalon slave: one wait state, write lands when waitrequest is low
    if (st_reg.av_wait) begin
      if (avs_read || avs_write) begin
        case (avs_address)
          `PSA_ADDR_TABLE_PAGE: rd = {24'h000000, st_reg.table_page};
          `PSA_ADDR_VIS_PAGE:   rd = {24'h000000, st_reg.visibility_page};
          `PSA_ADDR_CORE_CTRL: begin
            rd[`PSA_VIS_EN_BIT] = st_reg.visibility_enable;
          end
          `PSA_ADDR_STATUS:     rd = {30'h00000000, st_reg.cfg_last,
                                      st_reg.fsm != PSA_IDLE};
          `PSA_ADDR_PC:         rd = {8'h00, st_reg.program_counter};
          default:              rd = 32'h00000000;
        endcase
        st_next.av_wait = 1'b0;
        st_next.av_rdata = rd;
      end
    end else begin
      st_next.av_wait = 1'b1;
      if (avs_write && avs_byteenable[0]) begin
        case (avs_address)
          `PSA_ADDR_TABLE_PAGE: st_next.table_page = avs_writedata[7:0];
          `PSA_ADDR_VIS_PAGE:   st_next.visibility_page = avs_writedata[7:0];
          `PSA_ADDR_CORE_CTRL: begin
            st_next.visibility_enable = avs_writedata[`PSA_VIS_EN_BIT];
          end
          default: st_next.av_wait = 1'b1;
        endcase
      end
    end

    // Program counter: branch literal wins over the sequential step
    if (lit_valid && (lit_kind == PSA_LIT_BRANCH)) begin
      st_next.program_counter = st_reg.program_counter +
                                {{7{lit_field[15]}}, lit_field, 1'b0};
    end else if (pc_step) begin
      st_next.program_counter = st_reg.program_counter + `PSA_PC_STEP;
    end
    if (lit_valid && (lit_kind == PSA_LIT_DISABLE)) begin
      st_next.disable_count = lit_field[13:0];
    end

    case (st_reg.fsm)
      PSA_IDLE: begin
        if (idle_go) begin
          st_next.op = psa_op_e'(core_op);
          st_next.byte_mode = core_byte;
          st_next.ea = ea_now;
          st_next.vis = 1'b0;
          case (core_op)
            PSA_DATA_READ: begin
              if (vis_hit) begin
                st_next.vis = 1'b1;
                st_next.pm_addr = vis_addr(st_reg.visibility_page, ea_now);
                st_next.pm_cfg = 1'b0;
                st_next.pm_rd = 1'b1;
                st_next.fsm = PSA_ISSUE;
              end else begin
                st_next.done = 1'b1;
                st_next.data_space = 1'b1;
              end
            end
            PSA_DATA_WRITE: begin
              st_next.done = 1'b1;
              st_next.refused = vis_hit;
              st_next.data_space = !vis_hit;
            end
            PSA_TABLE_READ_LOW, PSA_TABLE_READ_HIGH: begin
              st_next.pm_addr = table_addr(st_reg.table_page, ea_now);
              st_next.pm_cfg = st_reg.table_page[`PSA_CFG_BIT];
              st_next.cfg_last = st_reg.table_page[`PSA_CFG_BIT];
              st_next.pm_rd = 1'b1;
              st_next.fsm = PSA_ISSUE;
            end
            PSA_TABLE_WRITE_LOW, PSA_TABLE_WRITE_HIGH: begin
              st_next.cfg_last = st_reg.table_page[`PSA_CFG_BIT];
              if (st_reg.table_page[`PSA_CFG_BIT]) begin
                st_next.done = 1'b1;
                st_next.refused = 1'b1;
              end else begin
                wl = write_lanes(core_op == PSA_TABLE_WRITE_HIGH, core_byte,
                                 ea_now[0], core_wdata);
                st_next.pm_addr = table_addr(st_reg.table_page, ea_now);
                st_next.pm_cfg = 1'b0;
                st_next.pm_wmask = wl[26:24];
                st_next.pm_wdata = wl[23:0];
                st_next.pm_wr = 1'b1;
                st_next.fsm = PSA_WDONE;
              end
            end
            default: begin
              st_next.done = 1'b1;
              st_next.refused = 1'b1;
            end
          endcase
        end
      end
      PSA_ISSUE: begin
        st_next.pm_rd = st_reg.vis;
        st_next.fsm = st_reg.vis ? PSA_SECOND : PSA_CAPT;
      end
      PSA_SECOND: begin
        st_next.fsm = PSA_CAPT;
      end
      PSA_CAPT: begin
        st_next.rdata = lane_data;
        st_next.done = 1'b1;
        st_next.fsm = PSA_IDLE;
      end
      PSA_WDONE: begin
        st_next.done = 1'b1;
        st_next.fsm = PSA_IDLE;
      end
      default: begin
        st_next.fsm = PSA_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= '{fsm: PSA_IDLE, op: PSA_DATA_READ, table_page: `PSA_RST_PAGE,
                  visibility_page: `PSA_RST_PAGE, av_wait: 1'b1,
                  program_counter: `PSA_RST_PC, default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign avs_readdata    = st_reg.av_rdata;
  assign avs_waitrequest = st_reg.av_wait;
  assign core_done       = st_reg.done;
  assign core_rdata      = st_reg.rdata;
  assign core_data_space = st_reg.data_space;
  assign core_refused    = st_reg.refused;
  assign program_counter = st_reg.program_counter;
  assign disable_count   = st_reg.disable_count;
  assign pm_addr         = st_reg.pm_addr;
  assign pm_rd           = st_reg.pm_rd;
  assign pm_wr           = st_reg.pm_wr;
  assign pm_wdata        = st_reg.pm_wdata;
  assign pm_wmask        = st_reg.pm_wmask;
  assign pm_cfg          = st_reg.pm_cfg;

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  logic tbl_rd_go;
  logic tbl_wr_go;
  logic vis_go;
  assign tbl_rd_go = idle_go && ((core_op == PSA_TABLE_READ_LOW) ||
                                 (core_op == PSA_TABLE_READ_HIGH));
  assign tbl_wr_go = idle_go && !st_reg.table_page[`PSA_CFG_BIT] &&
                     ((core_op == PSA_TABLE_WRITE_LOW) || (core_op == PSA_TABLE_WRITE_HIGH));
  assign vis_go = idle_go && (core_op == PSA_DATA_READ) && vis_hit;

  AST_TBL_ADDR: assert property (tbl_rd_go |=> pm_addr == {$past(st_reg.table_page),
      $past(calc_ea(core_ea_base, core_indexed, core_offset))})
    else $error("table address not page above EA");
  AST_CFG_SEL: assert property (tbl_rd_go |=> pm_cfg == $past(st_reg.table_page[7]))
    else $error("config space select wrong");
  AST_VIS_ADDR: assert property (vis_go |=> !pm_addr[23] &&
      pm_addr[22:15] == $past(st_reg.visibility_page) && pm_addr[14:0] == $past(ea_now[14:0]))
    else $error("visibility address wrong");
  AST_VIS_BIT15: assert property (vis_go |=> pm_addr[15] == $past(st_reg.visibility_page[0]))
    else $error("bit 15 not from page bit 0");
  AST_VIS_RO: assert property ((idle_go && core_op == PSA_DATA_WRITE)
      |=> !pm_wr && core_done ##1 !pm_wr)
    else $error("data write reached program memory");
  AST_VIS_TIMING: assert property (vis_go |=> pm_rd [*2] ##1 !pm_rd ##1 core_done)
    else $error("visibility read not two fetches");
  AST_TBL_TIMING: assert property (tbl_rd_go |=> pm_rd ##1 !pm_rd ##1 core_done)
    else $error("table read timing wrong");
  AST_REMAP_OFF: assert property ((idle_go && core_op == PSA_DATA_READ && !vis_hit)
      |=> core_done && core_data_space && !pm_rd)
    else $error("plain data read was remapped");
  AST_PHANTOM: assert property ((core_done && !core_refused &&
      st_reg.op == PSA_TABLE_READ_HIGH) |-> core_rdata[15:8] == 8'h00)
    else $error("phantom byte not zero");
  AST_HIGH_ONLY: assert property ((tbl_wr_go && core_op == PSA_TABLE_WRITE_LOW)
      |=> pm_wr && !pm_wmask[2])
    else $error("low write touched upper byte");
  AST_BYTE_SEL: assert property ((tbl_wr_go && core_op == PSA_TABLE_WRITE_LOW && core_byte
      && ea_now[0]) |=> pm_wmask == `PSA_MASK_MID_BYTE)
    else $error("byte select not EA bit 0");
  AST_PC_STEP: assert property ((pc_step && !lit_valid)
      |=> program_counter == $past(program_counter) + 24'h000002)
    else $error("program counter step not two");
  AST_DISABLE_LIT: assert property ((lit_valid && lit_kind == PSA_LIT_DISABLE)
      |=> disable_count == $past(lit_field[13:0]))
    else $error("disable count not loaded");
  AST_BUS_ANSWER: assert property (((avs_read || avs_write) && avs_waitrequest)
      |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer timing wrong");
  AST_TBL_WR_ADDR: assert property (tbl_wr_go |=> pm_wr && !pm_cfg &&
      pm_addr == {$past(st_reg.table_page), $past(ea_now)})
    else $error("table write address wrong");
  AST_CFG_WR_REFUSE: assert property ((idle_go && st_reg.table_page[`PSA_CFG_BIT] &&
      core_op[2] && !core_op[1]) |=> core_done && core_refused && !pm_wr)
    else $error("configuration write not refused");
  AST_LOW_WORD: assert property ((core_done && st_reg.op == PSA_TABLE_READ_LOW &&
      !st_reg.byte_mode) |-> core_rdata == $past(pm_rdata[15:0]))
    else $error("low word read data wrong");
  AST_LOW_BYTE: assert property ((core_done && st_reg.op == PSA_TABLE_READ_LOW &&
      st_reg.byte_mode) |-> core_rdata == {8'h00, st_reg.ea[0] ? $past(pm_rdata[15:8]) :
      $past(pm_rdata[7:0])})
    else $error("low byte read data wrong");
  AST_HIGH_WORD: assert property ((core_done && st_reg.op == PSA_TABLE_READ_HIGH &&
      !st_reg.byte_mode) |-> core_rdata == {8'h00, $past(pm_rdata[23:16])})
    else $error("high word read data wrong");
  AST_HIGH_BYTE: assert property ((core_done && st_reg.op == PSA_TABLE_READ_HIGH &&
      st_reg.byte_mode) |-> core_rdata ==
      (st_reg.ea[0] ? 16'h0000 : {8'h00, $past(pm_rdata[23:16])}))
    else $error("high byte read data wrong");
  AST_VIS_DATA: assert property ((core_done && st_reg.vis && !st_reg.byte_mode)
      |-> core_rdata == $past(pm_rdata[15:0]))
    else $error("remapped read not low word");
  AST_BRANCH: assert property ((lit_valid && lit_kind == PSA_LIT_BRANCH) |=>
      program_counter == $past(program_counter) +
      {{7{$past(lit_field[15])}}, $past(lit_field), 1'b0})
    else $error("branch literal not applied");
  AST_PAGE_WRITE: assert property ((avs_write && !avs_waitrequest && avs_byteenable[0] &&
      avs_address == `PSA_ADDR_TABLE_PAGE) |=> st_reg.table_page == $past(avs_writedata[7:0]))
    else $error("table page write lost");
  AST_PAGE_READ: assert property ((avs_read && avs_waitrequest &&
      avs_address == `PSA_ADDR_TABLE_PAGE) |=>
      avs_readdata == {24'h000000, $past(st_reg.table_page)})
    else $error("table page read wrong");

  COV_VIS: cover property (vis_go ##4 core_done);
  COV_TBL_HIGH: cover property (tbl_rd_go && core_op == PSA_TABLE_READ_HIGH ##3 core_done);
  COV_TBL_WR: cover property (tbl_wr_go ##1 pm_wr);
  COV_CFG_RD: cover property (tbl_rd_go && st_reg.table_page[7]);
  COV_REFUSED: cover property (core_done && core_refused);

endmodule : psa_top

// File: sim/psa_pm_model.sv
// Program memory model: serves the access unit's fetches and writes
// Assumes one clock; fetched data stands the cycle after a pm_rd cycle
`timescale 1ns/1ns
module psa_pm_model (
  input  wire logic        clk,
  input  wire logic [23:0] pm_addr,
  input  wire logic        pm_rd,
  input  wire logic        pm_wr,
  input  wire logic [23:0] pm_wdata,
  input  wire logic [2:0]  pm_wmask,
  input  wire logic        pm_cfg,
  output logic      [23:0] pm_rdata,
  output logic      [23:0] last_addr,
  output logic             last_cfg,
  output int               rd_count
);
  logic [23:0] mem [logic [23:0]];
  logic [23:0] k;
  logic [23:0] w;

  // Fill pattern of unwritten words
  function automatic logic [23:0] pat(input logic [23:0] a);
    return {a[7:0] ^ 8'hA5, a[15:8] ^ 8'hC3, a[23:16] ^ 8'h5A};
  endfunction : pat

  initial begin
    pm_rdata  = 24'h000000;
    last_addr = 24'h000000;
    last_cfg  = 1'b0;
    rd_count  = 0;
  end

  always @(posedge clk) begin
    k = {pm_addr[23:1], 1'b0};
    w = mem.exists(k) ? mem[k] : pat(k);
    if (pm_rd) begin
      pm_rdata  <= w;
      last_addr <= pm_addr;
      last_cfg  <= pm_cfg;
      rd_count  <= rd_count + 1;
    end else begin
      pm_rdata <= ~pm_rdata;
    end
    if (pm_wr) begin
      for (int i = 0; i < 3; i++) if (pm_wmask[i]) w[i*8 +: 8] = pm_wdata[i*8 +: 8];
      mem[k] = w;
    end
  end
endmodule : psa_pm_model

// File: sim/test_psa_top.sv
// Testbench of the program space access unit
// Assumes the program memory model and the unit share one 50 MHz clock
`timescale 1ns/1ns
`define TB_CHK(g, e, m) begin samples_checked++; if ((g) !== (e)) begin errors++; \
  $display("unexpected at %0t: %s", $time, m); end end
module test_psa_top;
  import psa_pkg::*;
  logic clk = 1'b0, rst = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0, avs_write = 1'b0, core_req = 1'b0, core_byte = 1'b0, core_indexed = 1'b0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic [3:0] avs_byteenable = 4'hF;
  logic avs_waitrequest, core_done, core_data_space, core_refused, pm_rd, pm_wr, pm_cfg;
  logic [2:0] core_op = 3'h0, pm_wmask;
  logic [15:0] core_ea_base = 16'h0, core_offset = 16'h0, core_wdata = 16'h0, core_rdata;
  logic pc_step = 1'b0, lit_valid = 1'b0, lit_kind = 1'b0, last_cfg;
  logic [15:0] lit_field = 16'h0;
  logic [23:0] program_counter, pm_addr, pm_wdata, pm_rdata, last_addr, w;
  logic [13:0] disable_count;
  logic [31:0] d;
  int errors = 0, samples_checked = 0, cycles = 0, n0, rd_count_w;
  logic [2:0] t_op [6] = '{3'h2, 3'h2, 3'h2, 3'h3, 3'h3, 3'h3};
  logic t_by [6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
  logic [15:0] t_ea [6] = '{16'h3456, 16'h3456, 16'h3457, 16'h3457, 16'h3456, 16'h3457};

  psa_top uut (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .core_req(core_req),
    .core_op(core_op), .core_byte(core_byte), .core_ea_base(core_ea_base),
    .core_indexed(core_indexed), .core_offset(core_offset), .core_wdata(core_wdata),
    .core_done(core_done), .core_rdata(core_rdata), .core_data_space(core_data_space),
    .core_refused(core_refused), .pc_step(pc_step), .lit_valid(lit_valid),
    .lit_kind(lit_kind), .lit_field(lit_field), .program_counter(program_counter),
    .disable_count(disable_count), .pm_addr(pm_addr), .pm_rd(pm_rd), .pm_wr(pm_wr),
    .pm_wdata(pm_wdata), .pm_wmask(pm_wmask), .pm_cfg(pm_cfg), .pm_rdata(pm_rdata));
  psa_pm_model pm (.clk(clk), .pm_addr(pm_addr), .pm_rd(pm_rd), .pm_wr(pm_wr),
    .pm_wdata(pm_wdata), .pm_wmask(pm_wmask), .pm_cfg(pm_cfg), .pm_rdata(pm_rdata),
    .last_addr(last_addr), .last_cfg(last_cfg), .rd_count(rd_count_w));

  initial begin
    forever #10 clk = ~clk;
  end

  task automatic conclude;
    if (errors == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      conclude();
    end
  end

  task automatic av_rd(input logic [4:0] a, output logic [31:0] q);
    @(posedge clk);
    avs_read <= 1'b1;
    avs_address <= a;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
  endtask : av_rd

  task automatic av_wr(input logic [4:0] a, input logic [7:0] v);
    @(posedge clk);
    avs_write <= 1'b1;
    avs_address <= a;
    avs_writedata <= {24'h000000, v};
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask : av_wr

  task automatic core_go(input logic [2:0] op, input logic by, input logic [15:0] ea,
      input logic idx, input logic [15:0] off, input logic [15:0] wd, input int lat,
      input logic ds, input logic rf);
    int n;
    n = 0;
    @(posedge clk);
    core_req <= 1'b1;
    core_op <= op;
    core_byte <= by;
    core_ea_base <= ea;
    core_indexed <= idx;
    core_offset <= off;
    core_wdata <= wd;
    do begin @(posedge clk); #1; n++; end while (core_done !== 1'b1 && n < 20);
    `TB_CHK(n, lat, "core latency")
    `TB_CHK({core_data_space, core_refused}, {ds, rf}, "core flags")
    @(posedge clk);
    core_req <= 1'b0;
  endtask : core_go

  function automatic logic [15:0] lane(input logic [23:0] p, input logic hi, by, bs);
    if (!hi) return by ? {8'h00, bs ? p[15:8] : p[7:0]} : p[15:0];
    return (by && bs) ? 16'h0000 : {8'h00, p[23:16]};
  endfunction : lane

  task automatic lit(input logic k, input logic [15:0] f);
    @(posedge clk);
    lit_valid <= 1'b1;
    lit_kind <= k;
    lit_field <= f;
    @(posedge clk);
    lit_valid <= 1'b0;
    @(posedge clk);
    #1;
  endtask : lit

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    av_wr(5'h14, 8'h5A);
    for (int a = 0; a < 6; a++) begin
      av_rd(5'(a * 4), d);
      `TB_CHK(d, 32'h0, "register reset or unmapped read")
    end
    av_wr(5'h00, 8'h12);
    av_rd(5'h00, d);
    `TB_CHK(d, 32'h12, "table page readback")
    for (int i = 0; i < 6; i++) begin
      core_go(t_op[i], t_by[i], t_ea[i], 1'b0, 16'hFFFF, 16'h0, 3, 1'b0, 1'b0);
      w = pm.pat({8'h12, t_ea[i][15:1], 1'b0});
      d = {16'h0000, lane(w, t_op[i][0], t_by[i], t_ea[i][0])};
      `TB_CHK(core_rdata, d[15:0], "table read data")
      `TB_CHK(last_addr, {8'h12, t_ea[i]}, "table address")
    end
    core_go(3'h2, 1'b0, 16'h1000, 1'b1, 16'h0246, 16'h0, 3, 1'b0, 1'b0);
    `TB_CHK(last_addr, 24'h121246, "indexed address")
    av_wr(5'h00, 8'h81);
    core_go(3'h3, 1'b0, 16'h0010, 1'b0, 16'h0, 16'h0, 3, 1'b0, 1'b0);
    `TB_CHK(last_cfg, 1'b1, "configuration space flag")
    w = pm.pat(24'h810010);
    `TB_CHK(core_rdata, {8'h00, w[23:16]}, "configuration read")
    av_rd(5'h0C, d);
    `TB_CHK(d, 32'h2, "last table op config status")
    core_go(3'h4, 1'b0, 16'h0010, 1'b0, 16'h0, 16'h1111, 1, 1'b0, 1'b1);
    av_wr(5'h00, 8'h12);
    core_go(3'h4, 1'b1, 16'h2001, 1'b0, 16'h0, 16'h0077, 2, 1'b0, 1'b0);
    core_go(3'h5, 1'b0, 16'h2000, 1'b0, 16'h0, 16'h00EE, 2, 1'b0, 1'b0);
    w = pm.pat(24'h122000);
    core_go(3'h2, 1'b0, 16'h2000, 1'b0, 16'h0, 16'h0, 3, 1'b0, 1'b0);
    `TB_CHK(core_rdata, {8'h77, w[7:0]}, "low write readback")
    core_go(3'h3, 1'b0, 16'h2000, 1'b0, 16'h0, 16'h0, 3, 1'b0, 1'b0);
    `TB_CHK(core_rdata, 16'h00EE, "high write readback")
    av_wr(5'h04, 8'h35);
    av_wr(5'h08, 8'h04);
    av_rd(5'h08, d);
    `TB_CHK(d, 32'h04, "core control readback")
    n0 = rd_count_w;
    core_go(3'h0, 1'b0, 16'h8ABC, 1'b0, 16'h0, 16'h0, 4, 1'b0, 1'b0);
    `TB_CHK(rd_count_w - n0, 2, "two fetches")
    `TB_CHK(last_addr, 24'h1A8ABC, "remap address")
    `TB_CHK(core_rdata, pm.pat(24'h1A8ABC) & 24'h00FFFF, "remap data")
    av_wr(5'h04, 8'h34);
    core_go(3'h0, 1'b1, 16'h8001, 1'b0, 16'h0, 16'h0, 4, 1'b0, 1'b0);
    `TB_CHK(last_addr, 24'h1A0001, "remap address page bit 0")
    w = pm.pat(24'h1A0000);
    `TB_CHK(core_rdata, {8'h00, w[15:8]}, "remap byte")
    core_go(3'h1, 1'b0, 16'h8ABC, 1'b0, 16'h0, 16'h1234, 1, 1'b0, 1'b1);
    core_go(3'h0, 1'b0, 16'h0ABC, 1'b0, 16'h0, 16'h0, 1, 1'b1, 1'b0);
    av_wr(5'h08, 8'h00);
    core_go(3'h0, 1'b0, 16'h8ABC, 1'b0, 16'h0, 16'h0, 1, 1'b1, 1'b0);
    core_go(3'h6, 1'b0, 16'h2000, 1'b0, 16'h0, 16'h0, 1, 1'b0, 1'b1);
    @(posedge clk);
    pc_step <= 1'b1;
    repeat (2) @(posedge clk);
    pc_step <= 1'b0;
    av_rd(5'h10, d);
    `TB_CHK(d, 32'h4, "program counter after two steps")
    lit(1'b0, 16'hFFFE);
    `TB_CHK(program_counter, 24'h000000, "signed branch")
    lit(1'b1, 16'hFFFF);
    `TB_CHK(disable_count, 14'h3FFF, "disable count field")
    conclude();
  end
endmodule : test_psa_top
